// >>> inc/i2c_status_tx_map.svh
`ifndef I2C_STATUS_TX_MAP_SVH
`define I2C_STATUS_TX_MAP_SVH

// Byte addresses on the register bus
`define I2C_CTRL_ADDR 32'hfef800a0
`define I2C_STATUS_ADDR 32'hfef800a4
`define I2C_TX_ADDR 32'hfef800a8
`define I2C_RX_ADDR 32'hfef800b0

// Control register fields
`define I2C_CTRL_ENABLE_BIT 0
`define I2C_CTRL_STOP_BIT 1
`define I2C_CTRL_START_BIT 2
`define I2C_CTRL_NACK_BIT 3
`define I2C_CTRL_RESET 4'h0

// Status register fields
`define I2C_STAT_COMPLETE_BIT 0
`define I2C_STAT_ACK_BIT 1
`define I2C_STAT_ERROR_BIT 2
`define I2C_STAT_RXDONE_BIT 3
`define I2C_STAT_BUSY_BIT 4
`define I2C_COMPLETE_RESET 1'b1
`define I2C_FLAG_RESET 1'b0

// Transmit byte: address in bits 7:1, direction in bit 0
`define I2C_TX_DIR_BIT 0
`define I2C_TX_RESET 8'h00
`define I2C_RX_RESET 8'h00

// Timing
`define I2C_CLK_HZ 50000000
`define I2C_BIT_RATE_HZ 100000
`define I2C_LAST_BIT 4'h8

`endif

// >>> inc/i2c_status_tx_pkg.sv
package i2c_status_tx_pkg;

  // Line sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_start,
    st_bits,
    st_stop
  } link_state_type;

  // Kind of byte transfer in progress
  typedef enum logic [1:0] {
    op_addr,
    op_write,
    op_read
  } op_kind_type;

endpackage

// >>> hdl/i2c_master_status_and_transmit.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2c_status_tx_map.svh"

module i2c_master_status_and_transmit
  import i2c_status_tx_pkg::*;
#(
  parameter int CLK_HZ = `I2C_CLK_HZ,
  parameter int BIT_RATE_HZ = `I2C_BIT_RATE_HZ
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Synchronous reset, high
  input wire logic i_wb_cyc, // Bus cycle
  input wire logic i_wb_stb, // Bus strobe
  input wire logic i_wb_we, // Bus write
  input wire logic [31:0] i_wb_adr, // Bus byte address
  input wire logic [3:0] i_wb_sel, // Bus byte enables
  input wire logic [31:0] i_wb_dat, // Bus write data
  output logic [31:0] o_wb_dat, // Bus read data
  output logic o_wb_ack, // Bus acknowledge
  input wire logic i_scl, // Clock line level
  output logic o_scl_o, // Clock line drive value
  output logic o_scl_oe, // Clock line pull low
  input wire logic i_sda, // Data line level
  output logic o_sda_o, // Data line drive value
  output logic o_sda_oe // Data line pull low
);

  // Quarter bit period in system clocks
  localparam int QUARTER = CLK_HZ / (4 * BIT_RATE_HZ);

  if (QUARTER < 2 || QUARTER > 65535) begin : g_bad_rate
    $error("Bit rate does not fit the system clock");
  end

  logic scl_meta, scl_sync, sda_meta, sda_sync;
  logic [15:0] div_count;
  logic tick;
  link_state_type state;
  op_kind_type op_kind;
  logic [1:0] phase;
  logic [3:0] bit_count;
  logic [7:0] shift;
  logic ack_seen;
  logic session, session_read;
  logic scl_low, sda_low;
  logic ctrl_enable, ctrl_stop, ctrl_start, ctrl_nack;
  logic [7:0] tx_byte, rx_byte;
  logic receive_done_flag, error_flag, ack_received_flag, operation_complete_flag;
  logic bus_req, bus_wr, bus_rd;
  logic hit_ctrl, hit_status, hit_tx, hit_rx;
  logic tx_wr, busy, go_start, go_stop, go_write, go_read, valid_op;
  logic bits_end, stop_end;
  logic [31:0] next_rdata;

  // Two flops on each line before anything looks at it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      scl_meta <= i_scl;
      scl_sync <= scl_meta;
      sda_meta <= i_sda;
      sda_sync <= sda_meta;
    end
  end

  // Bus decode; a request is served in the cycle before ack rises
  assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign bus_wr = bus_req & i_wb_we & i_wb_sel[0];
  assign bus_rd = bus_req & ~i_wb_we;
  assign hit_ctrl = (i_wb_adr == `I2C_CTRL_ADDR);
  assign hit_status = (i_wb_adr == `I2C_STATUS_ADDR);
  assign hit_tx = (i_wb_adr == `I2C_TX_ADDR);
  assign hit_rx = (i_wb_adr == `I2C_RX_ADDR);

  // Transmit writes become operations only while idle and enabled
  assign tx_wr = bus_wr & hit_tx;
  assign busy = (state != st_idle);
  assign go_start = tx_wr & ~busy & ctrl_enable & ctrl_start;
  assign go_stop = tx_wr & ~busy & ctrl_enable & ctrl_stop & ~ctrl_start;
  assign go_write = tx_wr & ~busy & ctrl_enable & ~ctrl_start & ~ctrl_stop
                    & session & ~session_read;
  // A new read waits until the last byte was collected
  assign go_read = tx_wr & ~busy & ctrl_enable & ~ctrl_start & ~ctrl_stop
                   & session & session_read & ~receive_done_flag;
  assign valid_op = go_start | go_stop | go_write | go_read;

  // End of a byte and end of a stop, on the last quarter
  assign bits_end = tick & (state == st_bits) & (phase == 2'd3)
                    & (bit_count == `I2C_LAST_BIT);
  assign stop_end = tick & (state == st_stop) & (phase == 2'd3);

  // Quarter-bit enable; held off while idle so the first quarter is whole
  always_ff @(posedge i_clk) begin
    if (i_rst || !busy) begin
      div_count <= 16'h0000;
    end else if (div_count == 16'(QUARTER - 1)) begin
      div_count <= 16'h0000;
    end else begin
      div_count <= div_count + 16'h0001;
    end
  end
  assign tick = busy & (div_count == 16'(QUARTER - 1));

  // Bus write
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_enable <= 1'b0;
      ctrl_stop <= 1'b0;
      ctrl_start <= 1'b0;
      ctrl_nack <= 1'b0;
    end else if (bus_wr && hit_ctrl && !error_flag) begin
      if (i_wb_dat[`I2C_CTRL_START_BIT] && i_wb_dat[`I2C_CTRL_STOP_BIT]) begin
        ctrl_enable <= 1'b0;
        ctrl_stop <= 1'b0;
        ctrl_start <= 1'b0;
        ctrl_nack <= 1'b0;
      end else begin
        ctrl_enable <= i_wb_dat[`I2C_CTRL_ENABLE_BIT];
        ctrl_stop <= i_wb_dat[`I2C_CTRL_STOP_BIT];
        ctrl_start <= i_wb_dat[`I2C_CTRL_START_BIT];
        ctrl_nack <= i_wb_dat[`I2C_CTRL_NACK_BIT];
      end
    end
  end

  // Transmit byte keeps its last accepted value for read-back
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_byte <= `I2C_TX_RESET;
    end else if (valid_op) begin
      tx_byte <= i_wb_dat[7:0];
    end
  end

  // Error: a new error in the clearing cycle survives
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      error_flag <= `I2C_FLAG_RESET;
    end else if (bus_wr && hit_ctrl && !error_flag && i_wb_dat[`I2C_CTRL_START_BIT]
                 && i_wb_dat[`I2C_CTRL_STOP_BIT]) begin
      error_flag <= 1'b1;
    end else if (bus_rd && hit_status) begin
      error_flag <= 1'b0;
    end
  end

  // Receive-done: set wins over the clearing read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      receive_done_flag <= `I2C_FLAG_RESET;
    end else if (bits_end && op_kind == op_read) begin
      receive_done_flag <= 1'b1;
    end else if (bus_rd && hit_rx) begin
      receive_done_flag <= 1'b0;
    end
  end

  // Acknowledge flag tracks address and write bytes only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_received_flag <= `I2C_FLAG_RESET;
    end else if (valid_op) begin
      ack_received_flag <= 1'b0;
    end else if (bits_end && op_kind != op_read) begin
      ack_received_flag <= ack_seen;
    end
  end

  // Complete flag
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      operation_complete_flag <= `I2C_COMPLETE_RESET;
    end else if (valid_op) begin
      operation_complete_flag <= 1'b0;
    end else if (bits_end || stop_end) begin
      operation_complete_flag <= 1'b1;
    end
  end

  // Line sequencer: four quarters per bit, clock high waits for the line
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= st_idle;
      op_kind <= op_addr;
      phase <= 2'd0;
      bit_count <= 4'h0;
      shift <= 8'h00;
      ack_seen <= 1'b0;
      session <= 1'b0;
      session_read <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      rx_byte <= `I2C_RX_RESET;
    end else if (state == st_idle) begin
      phase <= 2'd0;
      // Data is let go a cycle after the clock fell, never in the same cycle
      sda_low <= 1'b0;
      bit_count <= 4'h0;
      ack_seen <= 1'b0;
      shift <= i_wb_dat[7:0];
      if (go_start) begin
        state <= st_start;
        op_kind <= op_addr;
      end else if (go_stop) begin
        state <= st_stop;
      end else if (go_write) begin
        state <= st_bits;
        op_kind <= op_write;
      end else if (go_read) begin
        state <= st_bits;
        op_kind <= op_read;
      end
    // Clock is let go in quarter 1; quarter 2 waits until the line is seen high
    end else if (tick && !(phase == 2'd2 && !scl_sync)) begin
      phase <= phase + 2'd1;
      unique case (state)
        st_start: begin
          // Data released, clock released, data falls, clock falls
          unique case (phase)
            2'd0: sda_low <= 1'b0;
            2'd1: scl_low <= 1'b0;
            2'd2: sda_low <= 1'b1;
            2'd3: begin
              scl_low <= 1'b1;
              state <= st_bits;
            end
          endcase
        end
        st_bits: begin
          unique case (phase)
            2'd0: begin
              if (bit_count == `I2C_LAST_BIT) begin
                // Master answers reads; slave answers address and writes
                sda_low <= (op_kind == op_read) & ~ctrl_nack;
              end else begin
                sda_low <= (op_kind != op_read) & ~shift[7];
              end
            end
            2'd1: scl_low <= 1'b0;
            2'd2: begin
              if (bit_count == `I2C_LAST_BIT) begin
                ack_seen <= ~sda_sync;
              end else begin
                shift <= {shift[6:0], sda_sync};
              end
            end
            2'd3: begin
              scl_low <= 1'b1;
              bit_count <= bit_count + 4'h1;
              if (bit_count == `I2C_LAST_BIT) begin
                state <= st_idle;
                if (op_kind == op_read) begin
                  rx_byte <= shift;
                end
                if (op_kind == op_addr) begin
                  session <= 1'b1;
                  session_read <= tx_byte[`I2C_TX_DIR_BIT];
                end
              end
            end
          endcase
        end
        st_stop: begin
          // Clock low with data low, clock released, then data rises
          unique case (phase)
            2'd0: begin
              scl_low <= 1'b1;
              sda_low <= 1'b1;
            end
            2'd1: scl_low <= 1'b0;
            2'd2: sda_low <= 1'b0;
            2'd3: begin
              state <= st_idle;
              session <= 1'b0;
              session_read <= 1'b0;
            end
          endcase
        end
        default: state <= st_idle;
      endcase
    end
  end

  // Open-drain: only ever pull low
  assign o_scl_o = 1'b0;
  assign o_sda_o = 1'b0;
  assign o_scl_oe = scl_low;
  assign o_sda_oe = sda_low;

  // Read data selection
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_rdata[`I2C_CTRL_ENABLE_BIT] = ctrl_enable;
      next_rdata[`I2C_CTRL_STOP_BIT] = ctrl_stop;
      next_rdata[`I2C_CTRL_START_BIT] = ctrl_start;
      next_rdata[`I2C_CTRL_NACK_BIT] = ctrl_nack;
    end else if (hit_status) begin
      next_rdata[`I2C_STAT_COMPLETE_BIT] = operation_complete_flag;
      next_rdata[`I2C_STAT_ACK_BIT] = ack_received_flag;
      next_rdata[`I2C_STAT_ERROR_BIT] = error_flag;
      next_rdata[`I2C_STAT_RXDONE_BIT] = receive_done_flag;
      next_rdata[`I2C_STAT_BUSY_BIT] = busy;
    end else if (hit_tx) begin
      next_rdata[7:0] = tx_byte;
    end else if (hit_rx) begin
      next_rdata[7:0] = rx_byte;
    end
  end

  // One wait state; unmapped addresses answer with zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req;
      if (bus_rd) begin
        o_wb_dat <= next_rdata;
      end
    end
  end

endmodule

`default_nettype wire

// >>> verif/i2c_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2c_status_tx_map.svh"
module i2c_chk #(
  parameter int CLK_HZ = 50000000,
  parameter int BIT_RATE_HZ = 100000
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_wb_cyc, // Cycle
  input wire logic i_wb_stb, // Strobe
  input wire logic i_wb_we, // Write
  input wire logic [31:0] i_wb_adr, // Address
  input wire logic [3:0] i_wb_sel, // Enables
  input wire logic [31:0] i_wb_dat, // Write data
  input wire logic [31:0] o_wb_dat, // Read data
  input wire logic o_wb_ack, // Ack
  input wire logic i_scl, // Clock line
  input wire logic o_scl_o, // Clock value
  input wire logic o_scl_oe, // Clock pull
  input wire logic i_sda, // Data line
  input wire logic o_sda_o, // Data value
  input wire logic o_sda_oe // Data pull
);
  logic rd;
  // Read answer being taken by the master
  assign rd = o_wb_ack && i_wb_cyc && i_wb_stb && !i_wb_we;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  a_ack_one_wait: assert property
    (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack not after one wait");
  a_ack_pulse: assert property
    (o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
  a_stat_unused: assert property
    (rd && i_wb_adr == `I2C_STATUS_ADDR |-> o_wb_dat[31:5] == 27'h0)
    else $error("status upper bits set");
  a_busy_not_done: assert property
    (rd && i_wb_adr == `I2C_STATUS_ADDR && o_wb_dat[4] |-> !o_wb_dat[0])
    else $error("complete while busy");
  a_busy_no_ack: assert property
    (rd && i_wb_adr == `I2C_STATUS_ADDR && o_wb_dat[4] |-> !o_wb_dat[1])
    else $error("ack flag while busy");
  a_tx_low_byte: assert property
    (rd && i_wb_adr == `I2C_TX_ADDR |-> o_wb_dat[31:8] == 24'h0) else $error("tx upper bits");
  a_rx_low_byte: assert property
    (rd && i_wb_adr == `I2C_RX_ADDR |-> o_wb_dat[31:8] == 24'h0) else $error("rx upper bits");
  a_drive_low_only: assert property
    (!o_scl_o && !o_sda_o) else $error("line driven high");
  a_rst_release: assert property
    ($fell(i_rst) |-> !o_scl_oe && !o_sda_oe && !o_wb_ack) else $error("not idle after reset");
  c_error_seen: cover property (rd && i_wb_adr == `I2C_STATUS_ADDR && o_wb_dat[2]);
  c_rx_done: cover property (rd && i_wb_adr == `I2C_STATUS_ADDR && o_wb_dat[3]);
  c_data_pull: cover property ($rose(o_sda_oe));
endmodule
bind i2c_master_status_and_transmit i2c_chk #(.CLK_HZ(CLK_HZ), .BIT_RATE_HZ(BIT_RATE_HZ)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .i_scl(i_scl), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
  .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe));
`default_nettype wire

// >>> verif/i2c_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl, // Clock line
  input wire logic sda, // Data line
  input wire logic slow, // Stretch clock
  input wire logic [7:0] rd_byte, // Byte to send
  output logic sda_oe, // Pull data low
  output logic scl_oe = 0, // Pull clock low
  output logic [7:0] got // Last byte written
);
  int bitn = 9;
  logic first = 0, act = 0, rd = 0, ackd = 0, tx_on = 0;
  logic [7:0] sh;
  logic [2:0] idx;
  // Live from rd_byte so a new byte shows while the clock is low
  assign sda_oe = ackd | (tx_on & !rd_byte[3'd7 - idx]);
  // Start and stop framing
  always @(negedge sda) if (scl === 1'b1) {bitn, first, act} = {32'd0, 2'b10};
  always @(posedge sda) if (scl === 1'b1) act = 0;
  // Shift in; a master nack ends our read transmit
  always @(posedge scl) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    if (bitn == 8 && rd && !first && sda) act = 0;
    bitn = bitn + 1;
  end
  // Address match, ack and read bits change only while the clock is low
  always @(negedge scl) begin
    {ackd, tx_on} = 2'b00;
    if (bitn == 8) begin
      if (first) {act, rd} = {sh[7:1] == ADDR, sh[0]};
      else if (!rd) got = sh;
      ackd = act && (first || !rd);
      first = 0;
    end else if (bitn == 9) bitn = 0;
    if (act && rd && !first && bitn < 8) {tx_on, idx} = {1'b1, bitn[2:0]};
  end
  // Slow mode holds the clock low after each fall
  always @(negedge scl) begin
    if (slow) begin
      scl_oe = 1;
      #300;
      scl_oe = 0;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2c_status_tx_map.svh"
module tb;
  logic i_clk, i_rst, cyc, stb, we, scl_oe, sda_oe, s_scl, s_sda, slow, ack;
  logic [3:0] sel;
  logic [31:0] adr, wd, rdat, q, seed;
  logic [7:0] rbyte, got, b;
  int n_mismatch, comparisons, i;
  wire scl = ~(scl_oe | s_scl);
  wire sda = ~(sda_oe | s_sda);
  i2c_master_status_and_transmit #(.BIT_RATE_HZ(6250000)) dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack), .i_scl(scl), .o_scl_o(),
    .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(), .o_sda_oe(sda_oe));
  i2c_slave_model slv (.scl(scl), .sda(sda), .slow(slow), .rd_byte(rbyte),
    .sda_oe(s_sda), .scl_oe(s_scl), .got(got));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // Status with busy clear
  function automatic logic [31:0] stat(input logic r, e, a, c);
    return {28'h0, r, e, a, c};
  endfunction
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    {cyc, stb, we, sel, adr, wd} <= {2'b11, w, 4'hf, a, d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) begin
      n_mismatch++;
      test_done();
    end
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk(nm, q, e);
  endtask
  // Start an operation and poll status until done
  task automatic op(input logic [31:0] c, input logic [31:0] d);
    int n;
    wb(1, `I2C_CTRL_ADDR, c);
    wb(1, `I2C_TX_ADDR, d);
    n = 0;
    do begin
      wb(0, `I2C_STATUS_ADDR, 0);
      n++;
    end while ((q[4] || !q[0]) && n < 300);
    if (n >= 300) begin
      n_mismatch++;
      test_done();
    end
  endtask
  initial begin
    i_clk = 0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    {i_rst, cyc, stb, we, sel, adr, wd, slow, rbyte} = {1'b1, 80'h0};
    {seed, n_mismatch, comparisons} = {32'd493, 64'd0};
    repeat (4) @(posedge i_clk);
    i_rst <= 0;
    rd_chk("status", `I2C_STATUS_ADDR, stat(0, 0, 0, 1));
    rd_chk("tx", `I2C_TX_ADDR, 0);
    rd_chk("unmapped", 32'hfef800bc, 0);
    // Error, then a start attempt that must be dropped
    wb(1, `I2C_CTRL_ADDR, 32'h6);
    wb(1, `I2C_CTRL_ADDR, 32'h5);
    wb(1, `I2C_TX_ADDR, 32'h54);
    rd_chk("ctrl", `I2C_CTRL_ADDR, 0);
    rd_chk("status", `I2C_STATUS_ADDR, stat(0, 1, 0, 1));
    rd_chk("status", `I2C_STATUS_ADDR, stat(0, 0, 0, 1));
    op(32'h5, 32'h54);
    chk("status", q, stat(0, 0, 1, 1));
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      b = seed[7:0];
      slow <= seed[8];
      op(32'h1, {24'h0, b});
      chk("status", q, stat(0, 0, 1, 1));
      chk("got", {24'h0, got}, {24'h0, b});
    end
    rd_chk("tx", `I2C_TX_ADDR, {24'h0, b});
    op(32'h5, 32'h2a);
    chk("status", q, stat(0, 0, 0, 1));
    op(32'h5, 32'h55);
    chk("status", q, stat(0, 0, 1, 1));
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      {slow, rbyte} <= seed[8:0];
      op(i == 2 ? 32'h9 : 32'h1, seed);
      chk("status", q, stat(1, 0, 0, 1));
      wb(1, `I2C_TX_ADDR, seed);
      rd_chk("status", `I2C_STATUS_ADDR, stat(1, 0, 0, 1));
      rd_chk("rx", `I2C_RX_ADDR, {24'h0, rbyte});
      rd_chk("status", `I2C_STATUS_ADDR, stat(0, 0, 0, 1));
    end
    op(32'h3, 0);
    chk("status", q, stat(0, 0, 0, 1));
    chk("lines", {30'h0, scl, sda}, 32'h3);
    test_done();
  end
endmodule
`default_nettype wire
